//--- pbah_master.sv
`timescale 1ns/1ps
`default_nettype none
module pbah_master
    import pbah_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              cmd_valid_i,
    input  wire pbah_cmd_s         cmd_i,
    output logic                   cmd_ready_o,
    output logic                   rsp_valid_o,
    output pbah_rsp_s              rsp_o,
    output logic                   request_o,
    input  wire logic              grant_i,
    output logic                   grant_pass_o,
    input  wire logic              select_ack_i,
    output logic                   select_ack_o,
    output logic                   select_ack_oe_o,
    input  wire logic              bus_in_use_i,
    output logic                   bus_in_use_o,
    output logic                   bus_in_use_oe_o,
    output logic                   master_strobe_o,
    output logic                   master_strobe_oe_o,
    input  wire logic              slave_reply_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   addr_oe_o,
    output logic      [1:0]        cyc_o,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    input  wire logic              bus_clear_i,
    input  wire logic              line_power_warning_i
);
    logic [SYNC_W-1:0] sync_s;
    pbah_state_e       state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              lock_q;
    logic [ADDR_W-1:0] lock_addr_q;

    pbah_sync #(.W(SYNC_W)) u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i ({grant_i, select_ack_i, bus_in_use_i, slave_reply_i,
                   bus_clear_i, line_power_warning_i}),
        .sync_o  (sync_s)
    );

    wire grant_s   = sync_s[5];
    wire busy_s    = sync_s[3];
    wire reply_s   = sync_s[2];
    wire clear_s   = sync_s[1];
    wire warn_s    = sync_s[0];
    wire take_cmd  = cmd_valid_i && cmd_ready_o;
    wire is_write  = cmd_i.cyc[1]; // R22
    wire lock_ok   = is_write && (cmd_i.addr == lock_addr_q);
    wire cnt_zero  = (cnt_q == '0);
    wire rd_cyc    = !cyc_o[1];

    assign master_strobe_oe_o = bus_in_use_oe_o;
    assign select_ack_o       = select_ack_oe_o;
    assign bus_in_use_o       = bus_in_use_oe_o;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q         <= ST_IDLE;
            cnt_q           <= '0;
            lock_q          <= 1'b0;
            lock_addr_q     <= '0;
            cmd_ready_o     <= 1'b0;
            rsp_valid_o     <= 1'b0;
            rsp_o           <= '0;
            request_o       <= 1'b0;
            grant_pass_o    <= 1'b0;
            select_ack_oe_o <= 1'b0;
            bus_in_use_oe_o <= 1'b0;
            master_strobe_o <= 1'b0;
            addr_o          <= '0;
            addr_oe_o       <= 1'b0;
            cyc_o           <= CYC_WORD_READ;
            data_o          <= '0;
            data_oe_o       <= 1'b0;
        end else if (clear_s) begin
            state_q         <= ST_IDLE;
            lock_q          <= 1'b0;
            cmd_ready_o     <= 1'b0;
            rsp_valid_o     <= 1'b0;
            request_o       <= 1'b0;
            grant_pass_o    <= 1'b0;
            select_ack_oe_o <= 1'b0;
            bus_in_use_oe_o <= 1'b0;
            master_strobe_o <= 1'b0;
            addr_oe_o       <= 1'b0;
            data_oe_o       <= 1'b0;
        end else begin
            rsp_valid_o  <= 1'b0;
            // grant passes on unless we are requesting or holding select_ack
            grant_pass_o <= grant_s && !request_o && !select_ack_oe_o; // R2
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    cmd_ready_o <= 1'b1;
                    if (take_cmd && lock_q) begin
                        // locked read pending: only a write to the same address
                        if (lock_ok) begin // R16
                            cmd_ready_o <= 1'b0;
                            addr_o    <= cmd_i.addr;
                            cyc_o     <= cmd_i.cyc;
                            data_o    <= cmd_i.wdata;
                            addr_oe_o <= 1'b1;
                            data_oe_o <= 1'b1;
                            cnt_q     <= CNT_W'(SETTLE_CYC);
                            state_q   <= ST_SETUP;
                        end else begin
                            rsp_valid_o <= 1'b1;
                            rsp_o       <= '{err: 1'b1, rdata: '0};
                        end
                    end else if (take_cmd) begin
                        addr_o      <= cmd_i.addr;
                        cyc_o       <= cmd_i.cyc;
                        data_o      <= cmd_i.wdata;
                        if (warn_s) begin
                            rsp_valid_o <= 1'b1;
                            rsp_o       <= '{err: 1'b1, rdata: '0};
                        end else begin
                            cmd_ready_o <= 1'b0;
                            request_o   <= 1'b1;
                            state_q     <= ST_REQ;
                        end
                    end
                end
                ST_REQ: begin
                    if (grant_s) begin
                        request_o       <= 1'b0; // R2
                        select_ack_oe_o <= 1'b1; // R2
                        state_q         <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (!busy_s) begin // R5
                        bus_in_use_oe_o <= 1'b1; // R6
                        state_q         <= ST_TAKE;
                    end
                end
                ST_TAKE: begin
                    select_ack_oe_o <= 1'b0; // R6
                    addr_oe_o       <= 1'b1; // R9
                    data_oe_o       <= cyc_o[1]; // R9
                    cnt_q           <= CNT_W'(SETTLE_CYC);
                    state_q         <= ST_SETUP;
                end
                ST_SETUP: begin
                    if (cnt_zero) begin
                        master_strobe_o <= 1'b1; // R10
                        state_q         <= ST_WAITR;
                    end
                end
                ST_WAITR: begin
                    if (reply_s && rd_cyc) begin // R12
                        cnt_q   <= CNT_W'(DESKEW_CYC - 1);
                        state_q <= ST_DESKEW;
                    end else if (reply_s) begin
                        master_strobe_o <= 1'b0; // R11
                        cnt_q           <= CNT_W'(ADDR_HOLD_CYC);
                        state_q         <= ST_RELEASE;
                    end
                end
                ST_DESKEW: begin
                    if (cnt_zero) begin
                        rsp_o           <= '{err: 1'b0, rdata: data_i}; // R13
                        master_strobe_o <= 1'b0; // R13
                        cnt_q           <= CNT_W'(ADDR_HOLD_CYC);
                        state_q         <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (cnt_zero && !reply_s) begin // R14 R15
                        addr_oe_o   <= 1'b0;
                        data_oe_o   <= 1'b0;
                        rsp_valid_o <= 1'b1;
                        if (!rd_cyc) begin
                            rsp_o <= '{err: 1'b0, rdata: '0};
                        end
                        lock_q      <= (cyc_o == CYC_LOCKED_READ); // R16
                        lock_addr_q <= addr_o;
                        // keep the bus through the locked pair
                        bus_in_use_oe_o <= (cyc_o == CYC_LOCKED_READ); // R8 R16
                        cmd_ready_o     <= 1'b1;
                        state_q         <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i || clear_s);

    AST_CAPTURE_BLOCKS: assert property ( // R2
        select_ack_oe_o |-> !request_o && !grant_pass_o)
        else $error("grant captured while still requesting or passing");

    AST_ACK_UNTIL_FREE: assert property ( // R5
        $rose(bus_in_use_oe_o) && !lock_q |-> select_ack_oe_o && !$past(busy_s))
        else $error("bus taken before old master released it");

    AST_BUSY_THEN_DROP_ACK: assert property ( // R6
        $rose(bus_in_use_oe_o) |=> $fell(select_ack_oe_o))
        else $error("select_ack not dropped right after taking bus");

    AST_BUSY_COVERS_DATA: assert property ( // R8
        addr_oe_o || data_oe_o |-> bus_in_use_oe_o)
        else $error("data lines used without bus_in_use");

    AST_DATA_ONLY_WRITE: assert property ( // R9
        data_oe_o |-> cyc_o[1])
        else $error("data driven on a read cycle");

    AST_STROBE_SETTLED: assert property ( // R10
        $rose(master_strobe_o) |-> addr_oe_o && $past(addr_oe_o, SETTLE_CYC))
        else $error("strobe raised before address settled");

    AST_ADDR_STABLE: assert property ( // R10
        master_strobe_o && $past(master_strobe_o) |-> $stable(addr_o) && $stable(cyc_o))
        else $error("address or cycle type changed under strobe");

    AST_STROBE_AFTER_REPLY: assert property ( // R11
        $fell(master_strobe_o) |-> $past(reply_s))
        else $error("strobe dropped without slave reply");

    AST_READ_DESKEW: assert property ( // R13
        $fell(master_strobe_o) && !cyc_o[1] |-> $past(reply_s, DESKEW_CYC + 1))
        else $error("read data strobed before deskew elapsed");

    AST_ADDR_HOLD: assert property ( // R14
        $fell(addr_oe_o) |-> !$past(master_strobe_o) && !$past(master_strobe_o, 2))
        else $error("address removed inside hold time");

    AST_REPLY_GONE: assert property ( // R15
        $fell(addr_oe_o) |-> !$past(reply_s))
        else $error("address removed while slave still replying");

    AST_LOCK_PAIR: assert property ( // R16
        $rose(master_strobe_o) && lock_q |-> cyc_o[1] && addr_o == lock_addr_q)
        else $error("locked read not followed by write to same word");

    CV_READ:   cover property ($fell(master_strobe_o) && cyc_o == CYC_WORD_READ);
    CV_WRITE:  cover property ($fell(master_strobe_o) && cyc_o == CYC_WORD_WRITE);
    CV_LOCKED: cover property ($rose(master_strobe_o) && lock_q);
    CV_WAIT:   cover property (select_ack_oe_o && busy_s);

endmodule : pbah_master
`default_nettype wire

//--- pbah_pkg.sv
// Summary of operation
// R1 - Adaptor grants a pending, enabled level or dma request on its grant line.
// R2 - First requester on the chain captures grant, raises select_ack, blocks grant, drops request.
// R3 - Adaptor withdraws the grant as soon as it sees select_ack.
// R4 - Unclaimed grant at chain end is ORed back as select_ack.
// R5 - Selected unit holds select_ack until the old master drops bus_in_use.
// R6 - After bus_in_use falls, selected unit asserts bus_in_use, then drops select_ack.
// R7 - Arbiter keeps sampling and may grant during a transfer or interrupt.
// R8 - The master holds bus_in_use for as long as it uses the data lines.
// R9 - Master drives address and cycle type; data only on word or byte writes.
// R10 - Master asserts master_strobe after settling; strobe falls before address or type change.
// R11 - On writes the slave replies only after decoding and latching the data.
// R12 - On reads the slave replies only after driving the fetched data.
// R13 - On reads the master waits a deskew time, strobes data, drops master_strobe.
// R14 - Master waits a hold delay after strobe falls before removing address and type.
// R15 - After master_strobe falls the slave removes read data and drops slave_reply.
// R16 - A locked read is always followed by a write to the same location.
// R17 - When interrupts are serviced the adaptor accepts requests and passes the vector on.
// R18 - When interrupts are not serviced the adaptor ignores peripheral requests.
// R19 - Bus clear holds during supply fault and for 10 ms after it ends.
// R20 - Line power warning starts the power-fail trap; peripherals may wind down on it.
// R21 - The adaptor answers a dma request with the dma grant line.
// R22 - Cycle type code: 00 word read, 01 locked read, 10 word write, 11 byte write.
// R23 - Arbiter ranks dma highest, then levels seven down to four.
// R24 - The adaptor never asserts more than one level grant line at once.
// R25 - Asynchronous handshake inputs are synchronised before being acted on.
package pbah_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    localparam logic [1:0] CYC_WORD_READ   = 2'h0;
    localparam logic [1:0] CYC_LOCKED_READ = 2'h1;
    localparam logic [1:0] CYC_WORD_WRITE  = 2'h2;
    localparam logic [1:0] CYC_BYTE_WRITE  = 2'h3;

    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS     = 150;
    localparam int DESKEW_NS     = 75;
    localparam int ADDR_HOLD_NS  = 100;

    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc_up

    localparam int SETTLE_CYC    = ns_to_cyc_up(SETTLE_NS);
    localparam int DESKEW_CYC    = ns_to_cyc_up(DESKEW_NS);
    localparam int ADDR_HOLD_CYC = ns_to_cyc_up(ADDR_HOLD_NS);

    localparam int CNT_W = 4;

    localparam int SYNC_W = 6;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        cyc;
        logic [DATA_W-1:0] wdata;
    } pbah_cmd_s;

    typedef struct packed {
        logic              err;
        logic [DATA_W-1:0] rdata;
    } pbah_rsp_s;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_REQ     = 3'h1,
        ST_ACK     = 3'h2,
        ST_TAKE    = 3'h3,
        ST_SETUP   = 3'h4,
        ST_WAITR   = 3'h5,
        ST_DESKEW  = 3'h6,
        ST_RELEASE = 3'h7
    } pbah_state_e;

endpackage : pbah_pkg

//--- pbah_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pbah_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i; // R25
            sync_o <= meta_q;
        end
    end
endmodule : pbah_sync
`default_nettype wire

//--- pbah_far.sv
`timescale 1ns/1ps
`default_nettype none
module pbah_far
    import pbah_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              request_i,
    input  wire logic              select_ack_i,
    input  wire logic              strobe_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [1:0]        cyc_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [3:0]        delay_i,
    output logic                   grant_o,
    output logic                   reply_o,
    output logic      [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [16];
    logic [3:0]        wait_q;
    wire  [3:0]        idx = addr_i[4:1];
    wire               wr  = cyc_i[1];
    // far side moves on the falling edge, half a cycle off the master
    always @(negedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            grant_o <= 1'b0;
            reply_o <= 1'b0;
            wait_q  <= 4'h0;
            rdata_o <= 16'hA5A5;
            for (int i = 0; i < 16; i++) mem[i] <= {12'h100, 4'(i)};
        end else begin
            if (select_ack_i) grant_o <= 1'b0;
            else if (request_i) grant_o <= 1'b1;
            if (!strobe_i) begin
                reply_o <= 1'b0;
                wait_q  <= delay_i;
                rdata_o <= ~rdata_o;
            end else if (wait_q != 4'h0) begin
                wait_q  <= wait_q - 4'h1;
                rdata_o <= ~rdata_o;
            end else if (!reply_o) begin
                reply_o <= 1'b1;
                if (cyc_i == CYC_WORD_WRITE) mem[idx] <= wdata_i;
                else if (wr && addr_i[0]) mem[idx][15:8] <= wdata_i[15:8];
                else if (wr) mem[idx][7:0] <= wdata_i[7:0];
                else rdata_o <= mem[idx];
            end
        end
    end
endmodule : pbah_far
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import pbah_pkg::*;
;
    logic              mclk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cmd_valid_i = 1'b0;
    pbah_cmd_s         cmd_i = '0;
    logic              bus_clear_i = 1'b0;
    logic              line_power_warning_i = 1'b0;
    logic              other_busy = 1'b0;
    logic [3:0]        far_delay = 4'h0;
    logic              cmd_ready_o, rsp_valid_o, request_o, grant_pass_o, grant_w, reply_w;
    logic              select_ack_oe_o, bus_in_use_oe_o, master_strobe_o, master_strobe_oe_o;
    logic              addr_oe_o, data_oe_o, saw_req, saw_doe, order_ok;
    logic              select_ack_o, bus_in_use_o;
    pbah_rsp_s         rsp_o, rsp_q;
    logic [ADDR_W-1:0] addr_o;
    logic [1:0]        cyc_o;
    logic [DATA_W-1:0] data_o, far_rdata;
    int                miscompares = 0, comparisons = 0, cycles = 0, strobes;
    wire               select_ack_w = (select_ack_o & select_ack_oe_o) | (grant_pass_o & grant_w);
    wire               busy_w = (bus_in_use_o & bus_in_use_oe_o) | other_busy;
    wire               strobe_w = master_strobe_o & master_strobe_oe_o;
    wire  [DATA_W-1:0] data_w = data_oe_o ? data_o : far_rdata;

    pbah_master uut (.mclk_i, .rst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .rsp_valid_o,
        .rsp_o, .request_o, .grant_i(grant_w), .grant_pass_o, .select_ack_i(select_ack_w),
        .select_ack_o, .select_ack_oe_o, .bus_in_use_i(busy_w), .bus_in_use_o,
        .bus_in_use_oe_o, .master_strobe_o, .master_strobe_oe_o, .slave_reply_i(reply_w),
        .addr_o, .addr_oe_o, .cyc_o, .data_i(data_w), .data_o, .data_oe_o, .bus_clear_i,
        .line_power_warning_i);
    pbah_far far (.mclk_i, .rst_i, .request_i(request_o), .select_ack_i(select_ack_w),
        .strobe_i(strobe_w), .addr_i(addr_o), .cyc_i(cyc_o), .wdata_i(data_o),
        .delay_i(far_delay), .grant_o(grant_w), .reply_o(reply_w), .rdata_o(far_rdata));

    always #50 mclk_i = ~mclk_i;

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            $display("mismatch at %0t: run timed out", $time);
            complete_run();
        end
    end

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic take(input logic [1:0] c, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        int n;
        @(negedge mclk_i);
        cmd_i <= '{addr: a, cyc: c, wdata: d};
        cmd_valid_i <= 1'b1;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        cmd_valid_i <= 1'b0;
    endtask : take

    task automatic run(input logic [1:0] c, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        int n;
        take(c, a, d);
        saw_req = 1'b0;
        saw_doe = 1'b0;
        order_ok = 1'b1;
        strobes = 0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 300) begin
            if (request_o === 1'b1) saw_req = 1'b1;
            if (data_oe_o === 1'b1) saw_doe = 1'b1;
            if (strobe_w === 1'b1) strobes++;
            if (strobe_w === 1'b1 && (addr_oe_o !== 1'b1 || cyc_o !== c || addr_o !== a)) order_ok = 0;
            @(negedge mclk_i);
            n++;
        end
        rsp_q = rsp_o;
        check(rsp_valid_o === 1'b1, "no response");
    endtask : run

    task automatic t_rw;
        run(CYC_WORD_WRITE, 18'h00004, 16'h5A3C);
        check(rsp_q.err === 1'b0 && saw_req === 1'b1 && saw_doe === 1'b1, "write");
        check(order_ok === 1'b1 && far.mem[2] === 16'h5A3C, "write data");
        run(CYC_WORD_READ, 18'h00004, 16'h0000);
        check(rsp_q.rdata === 16'h5A3C && saw_doe === 1'b0, "read back");
        check(order_ok === 1'b1 && bus_in_use_oe_o === 1'b0, "read order");
        $display("test write read done");
    endtask : t_rw

    task automatic t_lock;
        run(CYC_BYTE_WRITE, 18'h00008, 16'h00EE);
        check(far.mem[4] === 16'h10EE && saw_doe === 1'b1, "byte write");
        run(CYC_LOCKED_READ, 18'h00008, 16'h0000);
        check(rsp_q.rdata === 16'h10EE && bus_in_use_oe_o === 1'b1, "locked read");
        run(CYC_WORD_READ, 18'h00008, 16'h0000);
        check(rsp_q.err === 1'b1 && bus_in_use_oe_o === 1'b1, "bad follow-up");
        run(CYC_WORD_WRITE, 18'h00008, 16'h1234);
        check(rsp_q.err === 1'b0 && far.mem[4] === 16'h1234, "locked write");
        check(bus_in_use_oe_o === 1'b0, "lock not released");
        $display("test lock done");
    endtask : t_lock

    task automatic t_slow;
        far_delay <= 4'h9;
        run(CYC_WORD_READ, 18'h00002, 16'h0000);
        check(rsp_q.rdata === 16'h1001 && strobes > 9, "slow read");
        far_delay <= 4'h0;
        $display("test slow done");
    endtask : t_slow

    task automatic t_arb;
        int n;
        other_busy <= 1'b1;
        fork
            run(CYC_WORD_READ, 18'h00006, 16'h0000);
            begin
                repeat (20) @(negedge mclk_i);
                check(select_ack_oe_o === 1'b1 && bus_in_use_oe_o === 1'b0, "hold");
                check(grant_w === 1'b0 && request_o === 1'b0, "grant kept");
                check(grant_pass_o === 1'b0, "captured grant passed on");
                other_busy <= 1'b0;
                n = 0;
                while (bus_in_use_oe_o !== 1'b1 && n < 10) begin
                    @(negedge mclk_i);
                    n++;
                end
                check(select_ack_oe_o === 1'b1, "select dropped early");
                @(negedge mclk_i);
                check(select_ack_oe_o === 1'b0, "select kept");
            end
        join
        check(rsp_q.rdata === 16'h1003, "handover read");
        $display("test arbitration done");
    endtask : t_arb

    task automatic t_power;
        line_power_warning_i <= 1'b1;
        repeat (4) @(negedge mclk_i);
        run(CYC_WORD_WRITE, 18'h0000A, 16'hBEEF);
        check(request_o === 1'b0, "request raised under warning");
        check(rsp_q.err === 1'b1 && saw_req === 1'b0 && far.mem[5] === 16'h1005, "warn");
        line_power_warning_i <= 1'b0;
        repeat (4) @(negedge mclk_i);
        $display("test power warning done");
    endtask : t_power

    task automatic t_clear;
        int n;
        far_delay <= 4'hF;
        take(CYC_WORD_READ, 18'h0000C, 16'h0000);
        n = 0;
        while (strobe_w !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        check(strobe_w === 1'b1, "no strobe");
        bus_clear_i <= 1'b1;
        repeat (5) @(negedge mclk_i);
        check(bus_in_use_oe_o === 1'b0 && strobe_w === 1'b0 && addr_oe_o === 1'b0, "clear");
        bus_clear_i <= 1'b0;
        far_delay <= 4'h0;
        repeat (6) @(negedge mclk_i);
        check(cmd_ready_o === 1'b1 && select_ack_oe_o === 1'b0, "idle after clear");
        $display("test bus clear done");
    endtask : t_clear

    initial begin
        repeat (8) @(posedge mclk_i);
        check(cmd_ready_o === 1'b0 && addr_oe_o === 1'b0 && cyc_o === 2'h0, "reset");
        @(negedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        check(cmd_ready_o === 1'b1, "not ready");
        $display("test reset done");
        t_rw();
        t_lock();
        t_slow();
        t_arb();
        t_power();
        t_clear();
        complete_run();
    end
endmodule : tb
`default_nettype wire
